//--- core/kme_encoder.sv
/*
  Keyboard matrix encoder: two ring counters scan an 8 by 11 switch
  matrix, the scan stops on a closed key and a 9-bit table word is
  presented with a debounced strobe.
  Assumes synchronous inputs, a 200 MHz core_clk and kme_map.svh on
  the include path.
*/
`timescale 1ns/100ps
`include "kme_map.svh"

module kme_encoder
  import kme_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic shift,
  input wire logic control,
  input wire logic data_strobe_invert,
  input wire logic parity_invert,
  input wire logic [`KME_DELAY_W-1:0] debounce_ticks,
  input wire logic [`KME_SENSE_W-1:0] matrix_sense_lines,
  output logic [`KME_DRIVE_W-1:0] matrix_drive_lines,
  output kme_code_t code_outputs,
  output logic strobe_out
);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Position of the single set bit of a ring
  function automatic logic [3:0] ring_pos(input logic [10:0] ring);
    logic [3:0] pos;
    pos = 4'h0;
    for (int i = 0; i < 11; i++) begin
      if (ring[i]) begin
        pos = 4'(i);
      end
    end
    return pos;
  endfunction

  // Group offset plus drive position times sense width plus sense position
  function automatic logic [`KME_ADDR_W-1:0] table_addr(
    input kme_group_t grp,
    input logic [3:0] xpos,
    input logic [3:0] ypos
  );
    int sum;
    sum = int'(grp) * `KME_GROUP_WORDS + int'(xpos) * `KME_SENSE_W
      + int'(ypos);
    return sum[`KME_ADDR_W-1:0];
  endfunction

  // Build-time contents: index as data, stored with odd parity
  function automatic kme_code_t table_word(input int idx);
    kme_code_t w;
    w.data = idx[7:0];
    w.parity = ~^idx[7:0];
    return w;
  endfunction

  // Fixed code table
  kme_code_t code_table [`KME_TABLE_WORDS];
  always_comb begin
    for (int i = 0; i < `KME_TABLE_WORDS; i++) begin
      code_table[i] = table_word(i);
    end
  end

  // Scan rate divider
  logic [`KME_DIV_W-1:0] div_count;
  logic [`KME_DIV_W-1:0] next_div_count;
  logic scan_tick;
  logic next_scan_tick;

  always_comb begin
    next_scan_tick = 1'b0;
    next_div_count = div_count + 1'b1;
    if (div_count == `KME_DIV_W'(`KME_SCAN_DIV - 1)) begin
      next_div_count = '0;
      next_scan_tick = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_count <= '0;
      scan_tick <= 1'b0;
    end else begin
      div_count <= next_div_count;
      scan_tick <= next_scan_tick;
    end
  end

  // Mode group: both shift and control give spurious data in the
  // original part; here control simply wins
  kme_group_t group_sel;
  always_comb begin
    if (control) begin
      group_sel = KME_GRP_CTRL;
    end else if (shift) begin
      group_sel = KME_GRP_SHIFT;
    end else begin
      group_sel = KME_GRP_NORMAL;
    end
  end

  // Ring counters, scan state and debounce
  kme_state_t state;
  kme_state_t next_state;
  logic [`KME_SENSE_W-1:0] sense_ring;
  logic [`KME_SENSE_W-1:0] next_sense_ring;
  logic [`KME_DRIVE_W-1:0] next_drive;
  logic key_match;
  logic delay_cond;
  logic delay_done;
  logic [`KME_ADDR_W-1:0] addr;
  kme_code_t word;

  // The driven line is the drive ring itself, so one flop serves both
  assign key_match = |(matrix_sense_lines & sense_ring);
  // Dropping the wait once done keeps a stale done out of the held state,
  // so a release right after entry is still debounced
  assign delay_cond = (state == KME_WAIT && key_match && !delay_done)
    || (state == KME_HELD && !key_match);
  assign addr = table_addr(group_sel, ring_pos({3'h0, matrix_drive_lines}),
    ring_pos(sense_ring));
  assign word = code_table[addr];

  kme_delay u_delay (
    .core_clk(core_clk),
    .rst(rst),
    .tick(scan_tick),
    .cond(delay_cond),
    .limit(debounce_ticks),
    .done(delay_done)
  );

  always_comb begin
    next_state = state;
    next_drive = matrix_drive_lines;
    next_sense_ring = sense_ring;
    case (state)
      KME_SCAN: begin
        if (scan_tick) begin
          if (key_match) begin
            next_state = KME_WAIT;
          end else begin
            next_drive = {matrix_drive_lines[6:0],
              matrix_drive_lines[7]};
            if (matrix_drive_lines[`KME_DRIVE_W-1]) begin
              next_sense_ring = {sense_ring[9:0], sense_ring[10]};
            end
          end
        end
      end
      KME_WAIT: begin
        if (!key_match) begin
          next_state = KME_SCAN;
        end else if (delay_done) begin
          next_state = KME_HELD;
        end
      end
      KME_HELD: begin
        // A second closed key is simply found by the resumed scan
        if (!key_match && delay_done) begin
          next_state = KME_SCAN;
        end
      end
      default: begin
        next_state = KME_SCAN;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= KME_SCAN;
      matrix_drive_lines <= `KME_DRIVE_RST;
      sense_ring <= `KME_SENSE_RST;
    end else begin
      state <= next_state;
      matrix_drive_lines <= next_drive;
      sense_ring <= next_sense_ring;
    end
  end

  // Output stage; polarity controls act on every cycle
  kme_code_t next_code;
  logic next_strobe;

  always_comb begin
    next_code.data = word.data ^ {`KME_DATA_W{data_strobe_invert}};
    next_code.parity = word.parity ^ parity_invert;
    next_strobe = (state == KME_HELD) ^ data_strobe_invert;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      code_outputs <= '0;
      strobe_out <= 1'b0;
    end else begin
      code_outputs <= next_code;
      strobe_out <= next_strobe;
    end
  end

  a_rings_onehot: assert property (
    $onehot(matrix_drive_lines) && $onehot(sense_ring))
    else $error("Ring counter lost its single set bit");

  a_addr_range: assert property (
    addr < `KME_ADDR_W'(`KME_TABLE_WORDS))
    else $error("Table address beyond last word");

  a_scan_steps: assert property (
    state == KME_SCAN && scan_tick && !key_match
      |=> matrix_drive_lines != $past(matrix_drive_lines))
    else $error("Scan tick did not step the drive ring");

  a_rings_stop: assert property (
    $past(state) != KME_SCAN
      |-> $stable(matrix_drive_lines) && $stable(sense_ring))
    else $error("Rings moved while scanning was stopped");

  a_match_stops: assert property (
    state == KME_SCAN && scan_tick && key_match |=> state == KME_WAIT)
    else $error("Match did not stop the scan");

  a_strobe_idle: assert property (
    state != KME_HELD ##1 $stable(data_strobe_invert)
      |-> strobe_out == data_strobe_invert)
    else $error("Strobe active without a held key");

  a_held_after_wait: assert property (
    $rose(state == KME_HELD) |-> $past(state) == KME_WAIT
      && $past(delay_done))
    else $error("Strobe went valid without the debounce delay");

  a_code_stable: assert property (
    state == KME_HELD && $past(state) == KME_HELD
      && $stable(data_strobe_invert) && $stable(parity_invert)
      && $stable(shift) && $stable(control)
      |=> $stable(code_outputs))
    else $error("Code changed while the key was held");

  a_data_polarity: assert property (
    1'b1 |=> code_outputs.data
      == ($past(word.data) ^ {`KME_DATA_W{$past(data_strobe_invert)}}))
    else $error("Data polarity does not follow the invert input");

  a_parity_polarity: assert property (
    1'b1 |=> code_outputs.parity
      == ($past(word.parity) ^ $past(parity_invert)))
    else $error("Parity polarity does not follow its invert input");

  a_release_resumes: assert property (
    state == KME_HELD && !key_match && delay_done |=> state == KME_SCAN
      ##1 strobe_out == $past(data_strobe_invert))
    else $error("Release did not drop strobe and resume scan");

endmodule

//--- core/kme_map.svh
/*
  Constants for the keyboard matrix encoder: ring sizes, table shape,
  reset values and scan timing.
  Assumes a 200 MHz core clock; included by bare name.
*/
`ifndef KME_MAP_SVH
`define KME_MAP_SVH

// Matrix and table shape
`define KME_DRIVE_W 8
`define KME_SENSE_W 11
`define KME_GROUP_WORDS 88
`define KME_TABLE_WORDS 264
`define KME_ADDR_W 9
`define KME_DATA_W 8
`define KME_DELAY_W 8

// Field positions inside one stored word
`define KME_PARITY_BIT 8
`define KME_DATA_LSB 0

// Reset values of the two ring counters
`define KME_DRIVE_RST 8'h01
`define KME_SENSE_RST 11'h001

// Scan clock: 50 kHz nominal, i.e. a 20000 ns period
`define KME_CLK_PERIOD_NS 5
`define KME_SCAN_PERIOD_NS 20000
`define KME_SCAN_DIV (`KME_SCAN_PERIOD_NS / `KME_CLK_PERIOD_NS)
`define KME_DIV_W 12

`endif

//--- core/kme_pkg.sv
/*
  Types shared by the keyboard matrix encoder files.
  Assumes kme_map.svh is on the include path.
*/
package kme_pkg;

  // One table word: parity on top, eight data bits below
  typedef struct packed {
    logic parity;
    logic [7:0] data;
  } kme_code_t;

  typedef enum logic [1:0] {
    KME_GRP_NORMAL,
    KME_GRP_SHIFT,
    KME_GRP_CTRL
  } kme_group_t;

  typedef enum logic [1:0] {
    KME_SCAN,
    KME_WAIT,
    KME_HELD
  } kme_state_t;

endpackage

//--- core/kme_delay.sv
/*
  Debounce delay: counts scan ticks while its condition holds and
  raises done once more than the programmed number of ticks passed.
  Assumes tick is a one-cycle enable from the scan divider.
*/
`timescale 1ns/100ps
`include "kme_map.svh"

module kme_delay
  import kme_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic cond,
  input wire logic [`KME_DELAY_W-1:0] limit,
  output logic done
);

  logic [`KME_DELAY_W:0] count;
  logic [`KME_DELAY_W:0] next_count;
  logic next_done;

  // Any gap in the condition restarts the wait, so bounce never adds up
  always_comb begin
    next_count = count;
    if (!cond) begin
      next_count = '0;
    end else if (tick && !done) begin
      next_count = count + 1'b1;
    end
    next_done = cond && (next_count > {1'b0, limit});
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
    end
  end

  a_done_needs_cond: assert property (@(posedge core_clk) disable iff (rst)
    $rose(done) |-> $past(cond)
      && ($past(tick) || $past(limit) != $past(limit, 2)))
    else $error("Delay done without a held condition");

endmodule

//--- verification/kme_keyboard_model.sv
/*
  Far side of the encoder: a passive switch matrix and a host latch.
  Assumes key bits indexed x*11+y and open sense lines pulled low.
*/
`timescale 1ns/100ps
`include "kme_map.svh"

module kme_keyboard_model
  import kme_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [`KME_DRIVE_W-1:0] matrix_drive_lines,
  input wire logic [`KME_DRIVE_W*`KME_SENSE_W-1:0] keys_closed,
  input wire kme_code_t code_outputs,
  input wire logic strobe_out,
  input wire logic data_strobe_invert,
  output logic [`KME_SENSE_W-1:0] matrix_sense_lines,
  output kme_code_t latched_code,
  output logic latch_event
);
  logic valid;
  logic prev;

  // A closed key joins its drive line to its sense line
  always_comb begin
    matrix_sense_lines = '0;
    for (int x = 0; x < `KME_DRIVE_W; x++) begin
      for (int y = 0; y < `KME_SENSE_W; y++) begin
        if (matrix_drive_lines[x] && keys_closed[x*`KME_SENSE_W+y]) begin
          matrix_sense_lines[y] = 1'b1;
        end
      end
    end
  end

  assign valid = strobe_out ^ data_strobe_invert;

  // Host takes the word on the rising edge of the valid level only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // Seen as valid in reset, so an inverted idle strobe is no edge
      prev <= 1'b1;
      latch_event <= 1'b0;
      latched_code <= '0;
    end else begin
      prev <= valid;
      latch_event <= valid & ~prev;
      if (valid && !prev) begin
        latched_code <= code_outputs;
      end
    end
  end
endmodule

//--- verification/test_keyboard_matrix_encoder.sv
/*
  Self-checking bench for the matrix encoder with a keyboard model.
  Assumes the fixed 4000-clock scan tick; keys stay on sense line 0.
*/
`timescale 1ns/100ps
`include "kme_map.svh"

module test_keyboard_matrix_encoder
  import kme_pkg::*;
;
  logic core_clk, rst, shift, control, dsi, parity_invert;
  logic [`KME_DELAY_W-1:0] debounce_ticks;
  logic [`KME_SENSE_W-1:0] sense;
  logic [`KME_DRIVE_W-1:0] drive;
  logic [`KME_DRIVE_W*`KME_SENSE_W-1:0] keys;
  kme_code_t code, latched;
  logic strobe, latch_event;
  kme_code_t exp_q[$];
  int err_total, cmp_count;

  kme_encoder kme_encoder_i (.core_clk(core_clk), .rst(rst), .shift(shift),
    .control(control), .data_strobe_invert(dsi),
    .parity_invert(parity_invert), .debounce_ticks(debounce_ticks),
    .matrix_sense_lines(sense), .matrix_drive_lines(drive),
    .code_outputs(code), .strobe_out(strobe));

  kme_keyboard_model kme_keyboard_model_i (.core_clk(core_clk), .rst(rst),
    .matrix_drive_lines(drive), .keys_closed(keys), .code_outputs(code),
    .strobe_out(strobe), .data_strobe_invert(dsi),
    .matrix_sense_lines(sense), .latched_code(latched),
    .latch_event(latch_event));

  task automatic check(input string what, input logic [8:0] seen,
                       input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wait_strobe(input logic want);
    int n;
    n = 0;
    while ((strobe ^ dsi) !== want) begin
      @(negedge core_clk);
      n++;
      if (n > 30000) begin
        check("strobe wait", 9'(~want), 9'(want));
        close_out();
      end
    end
  endtask

  // Mode g: 0 normal, 1 shift, 2 control with shift also high
  task automatic do_key(input int g, input int x, input int roll);
    kme_code_t e;
    logic [8:0] a;
    shift = (g != 0);
    control = (g == 2);
    parity_invert = 1'($urandom);
    a = 9'(g * 88 + x * 11);
    e.data = a[7:0] ^ {8{dsi}};
    e.parity = (~^a[7:0]) ^ parity_invert;
    exp_q.push_back(e);
    keys[x*11] = 1'b1;
    wait_strobe(1'b1);
    repeat (2000) @(negedge core_clk);
    check("held code", code, e);
    check("frozen drive", 9'(drive), 9'(1 << x));
    if (roll >= 0) begin
      keys[roll*11] = 1'b1;
    end
    keys[x*11] = 1'b0;
    wait_strobe(1'b0);
  endtask

  always @(negedge core_clk) begin
    if (latch_event) begin
      if (exp_q.size() == 0) begin
        check("extra strobe", 9'(1), 9'(0));
      end else begin
        check("latched code", latched, exp_q.pop_front());
      end
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    void'($urandom(32'hB3EA18EA));
    err_total = 0;
    cmp_count = 0;
    rst = 1'b1;
    dsi = 1'($urandom);
    shift = 1'b0;
    control = 1'b0;
    parity_invert = 1'b0;
    debounce_ticks = 8'($urandom_range(1, 0));
    keys = '0;
    repeat (10) @(negedge core_clk);
    check("drive in reset", 9'(drive), 9'h001);
    check("strobe in reset", 9'(strobe), 9'h000);
    rst = 1'b0;
    repeat (3000) @(negedge core_clk);
    check("idle strobe", 9'(strobe), 9'(dsi));
    do_key(1, 1, 3);
    do_key(2, 3, -1);
    do_key(0, 6, -1);
    repeat (20) @(negedge core_clk);
    check("notes left", 9'(exp_q.size()), 9'h000);
    close_out();
  end
endmodule
